// ### design/sprs_pkg.sv
// Constants and types shared by the serial port and ready logic
// ****************************************************************
// Function
// [RL1] Output bits launch on falling serial clock, valid at next rising edge.
// [RL2] Combined output/ready pin floats whenever chip select is high.
// [RL3] Selected and not reading, the pin is a ready flag, low on new result.
// [RL4] An unread result lets the flag return high before the next update.
// [RL5] Host may use the ready falling edge as a result-available interrupt.
// [RL6] Input bits are sampled on rising serial clock edges.
// [RL7] Input shift register contents go to the register the address field picks.
// [RL8] Output shift register loads from any on-chip data or control register.
// [RL9] Chip select is active low and selects this converter on a shared bus.
// [RL10] Host may tie chip select low permanently.
// [RL11] Chip select tied low gives 3-wire operation on clock, input, output.
// [RL12] Second crystal pin is crystal, clock input or clock output per select.
// [RL13] Serial words move most significant bit first in both directions.
// ****************************************************************
package sprs_pkg;
    localparam int WORD_W = 24;
    localparam int CMD_W = 8;
    localparam int ADDR_W = 6;
    localparam int CNT_W = 5;
    // Command byte layout
    localparam int CMD_WEN_BIT = 7;
    localparam int CMD_RD_BIT = 6;
    // Register indices
    localparam logic [5:0] REG_STATUS = 6'h00;
    localparam logic [5:0] REG_MODE = 6'h01;
    localparam logic [5:0] REG_DATA = 6'h04;
    localparam logic [5:0] REG_LAST = 6'h07;
    localparam int NREGS = 8;
    localparam logic [23:0] REG_RESET = 24'h000000;
    // Field positions
    localparam int MODE_CLKSEL_LSB = 2;
    localparam int STATUS_RDY_BIT = 7;
    // Clock source select encodings
    localparam logic [1:0] CLKSEL_INT = 2'h0;
    localparam logic [1:0] CLKSEL_INT_OUT = 2'h1;
    localparam logic [1:0] CLKSEL_EXT_IN = 2'h2;
    localparam logic [1:0] CLKSEL_XTAL = 2'h3;
    // Timing
    localparam int CLK_SYS_NS = 25;
    localparam int RDY_HIGH_NS = 100;
    localparam int RDY_HIGH_CYC = (RDY_HIGH_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
    localparam int CLKOUT_HALF = 2;

    typedef enum logic [1:0] {
        SPRS_COMMS = 2'b00,
        SPRS_WDATA = 2'b01,
        SPRS_RDATA = 2'b10
    } sprs_link_t;

    typedef enum logic [1:0] {
        SPRS_EMPTY = 2'b00,
        SPRS_VALID = 2'b01,
        SPRS_GAP = 2'b10
    } sprs_rdy_t;
endpackage : sprs_pkg

// ### design/sprs_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module sprs_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb
    begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule : sprs_sync

// ### design/sprs_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sprs_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage has no reset; only the count words from rd_ptr onward are ever read
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end
endmodule : sprs_fifo

// ### design/sprs_port.sv
// Serial host port with shared data-out / ready pin and clock pin control
`timescale 1ns/100ps
module sprs_port #(
    parameter int FIFO_DEPTH = 8,
    parameter int RDY_HIGH_CYCLES = sprs_pkg::RDY_HIGH_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    input wire logic conv_valid,
    output logic conv_ready,
    input wire logic [sprs_pkg::WORD_W-1:0] conv_data,
    input wire logic crystal2_clock_pin_in,
    output logic crystal2_clock_pin_out,
    output logic crystal2_clock_pin_oe,
    output logic xtal_osc_en,
    output logic [1:0] clock_source_select,
    output logic mod_clk_tick
);
    localparam int WW = sprs_pkg::WORD_W;
    localparam int CW = sprs_pkg::CNT_W;

    // ****************************************************************
    // Link domain, clocked by the serial clock
    // ****************************************************************
    sprs_pkg::sprs_link_t state;
    sprs_pkg::sprs_link_t next_state;
    logic [CW-1:0] bit_cnt;
    logic [CW-1:0] next_bit_cnt;
    logic [WW-1:0] rx_sr;
    logic [WW-1:0] next_rx_sr;
    logic [sprs_pkg::ADDR_W-1:0] addr;
    logic [sprs_pkg::ADDR_W-1:0] next_addr;
    logic [WW-1:0] regs [sprs_pkg::NREGS];
    logic [WW-1:0] next_regs [sprs_pkg::NREGS];
    logic cfg_tgl;
    logic next_cfg_tgl;
    logic [WW-1:0] tx_sr;
    logic [WW-1:0] next_tx_sr;
    logic tx_live;
    logic next_tx_live;
    logic link_rst_n;
    logic [sprs_pkg::CMD_W-1:0] cmd;
    logic [WW-1:0] wr_word;
    logic [WW-1:0] rd_word;
    logic reading;
    logic data_busy;

    // System-domain state read by the link
    logic rdy_n;
    logic [WW-1:0] result;

    // Deselect clears the frame; the serial clock may stop outside frames
    assign link_rst_n = rst_n && !cs_n; // RL9

    always_comb
    begin
        cmd = {rx_sr[sprs_pkg::CMD_W-2:0], din};
        wr_word = {rx_sr[WW-2:0], din};
        next_state = state;
        next_bit_cnt = bit_cnt + 1'b1;
        next_rx_sr = {rx_sr[WW-2:0], din}; // RL6 RL13
        next_addr = addr;
        next_cfg_tgl = cfg_tgl;
        for (int i = 0; i < sprs_pkg::NREGS; i++)
        begin
            next_regs[i] = regs[i];
        end
        unique case (state)
            sprs_pkg::SPRS_COMMS:
            begin
                if (bit_cnt == CW'(sprs_pkg::CMD_W - 1))
                begin
                    next_bit_cnt = '0;
                    // Bytes with the enable bit high are not commands
                    if (!cmd[sprs_pkg::CMD_WEN_BIT])
                    begin
                        next_addr = cmd[sprs_pkg::ADDR_W-1:0];
                        next_state = cmd[sprs_pkg::CMD_RD_BIT] ? sprs_pkg::SPRS_RDATA
                                                                 : sprs_pkg::SPRS_WDATA;
                    end
                end
            end
            sprs_pkg::SPRS_WDATA:
            begin
                if (bit_cnt == CW'(WW - 1))
                begin
                    next_bit_cnt = '0;
                    next_state = sprs_pkg::SPRS_COMMS;
                    // Status and data are read-only; unmapped writes drop
                    if (addr <= sprs_pkg::REG_LAST && addr != sprs_pkg::REG_STATUS
                        && addr != sprs_pkg::REG_DATA)
                    begin
                        next_regs[addr[2:0]] = wr_word; // RL7
                    end
                    if (addr == sprs_pkg::REG_MODE)
                    begin
                        next_cfg_tgl = !cfg_tgl;
                    end
                end
            end
            sprs_pkg::SPRS_RDATA:
            begin
                if (bit_cnt == CW'(WW - 1))
                begin
                    next_bit_cnt = '0;
                    next_state = sprs_pkg::SPRS_COMMS;
                end
            end
            default:
            begin
                next_bit_cnt = '0;
                next_state = sprs_pkg::SPRS_COMMS;
            end
        endcase
    end

    always_ff @(posedge sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            state <= sprs_pkg::SPRS_COMMS;
            bit_cnt <= '0;
            rx_sr <= '0;
            addr <= '0;
        end
        else
        begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            rx_sr <= next_rx_sr;
            addr <= next_addr;
        end
    end

    // Settings survive deselect; only the system reset clears them
    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_tgl <= 1'b0;
            for (int i = 0; i < sprs_pkg::NREGS; i++)
            begin
                regs[i] <= sprs_pkg::REG_RESET;
            end
        end
        else
        begin
            cfg_tgl <= next_cfg_tgl;
            for (int i = 0; i < sprs_pkg::NREGS; i++)
            begin
                regs[i] <= next_regs[i];
            end
        end
    end

    // Result and ready are held still by the system side while the data register is read
    always_comb
    begin
        rd_word = '0;
        if (addr == sprs_pkg::REG_STATUS)
        begin
            rd_word[sprs_pkg::STATUS_RDY_BIT] = rdy_n;
        end
        else if (addr == sprs_pkg::REG_DATA)
        begin
            rd_word = result;
        end
        else if (addr <= sprs_pkg::REG_LAST)
        begin
            rd_word = regs[addr[2:0]]; // RL8
        end
    end

    always_comb
    begin
        next_tx_sr = tx_sr;
        next_tx_live = tx_live;
        if (state != sprs_pkg::SPRS_RDATA)
        begin
            next_tx_live = 1'b0;
        end
        else if (!tx_live)
        begin
            next_tx_sr = rd_word; // RL8
            next_tx_live = 1'b1;
        end
        else
        begin
            next_tx_sr = {tx_sr[WW-2:0], 1'b0}; // RL13
        end
    end

    always_ff @(negedge sclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            tx_sr <= '0;
            tx_live <= 1'b0;
        end
        else
        begin
            tx_sr <= next_tx_sr; // RL1
            tx_live <= next_tx_live;
        end
    end

    assign reading = (state == sprs_pkg::SPRS_RDATA) && tx_live;
    assign data_busy = (state == sprs_pkg::SPRS_RDATA) && (addr == sprs_pkg::REG_DATA);
    assign dout = reading ? tx_sr[WW-1] : rdy_n; // RL1 RL3 RL11
    assign dout_oe = !cs_n; // RL2 RL11

    // ****************************************************************
    // Crossings into the system domain
    // ****************************************************************
    logic [2:0] sync_q;
    logic cfg_tgl_s;
    logic busy_s;
    logic ext_clk_s;

    sprs_sync #(
        .W(3)
    ) u_sync (
        .clk(clk_sys),
        .rst_n(rst_n),
        .d({cfg_tgl, data_busy, crystal2_clock_pin_in}),
        .q(sync_q)
    );

    assign cfg_tgl_s = sync_q[2];
    assign busy_s = sync_q[1];
    assign ext_clk_s = sync_q[0];

    // ****************************************************************
    // Result FIFO and ready flag
    // ****************************************************************
    logic fifo_valid;
    logic fifo_pop;
    logic [WW-1:0] fifo_data;
    sprs_pkg::sprs_rdy_t rstate;
    sprs_pkg::sprs_rdy_t next_rstate;
    logic [7:0] gap_cnt;
    logic [7:0] next_gap_cnt;
    logic next_rdy_n;
    logic [WW-1:0] next_result;
    logic busy_d;
    logic cfg_tgl_d;

    sprs_fifo #(
        .W(WW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk_sys),
        .rst_n(rst_n),
        .in_valid(conv_valid),
        .in_ready(conv_ready),
        .in_data(conv_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // Updates stall during a data read, so the FIFO backs up to the source
    always_comb
    begin
        next_rstate = rstate;
        next_gap_cnt = gap_cnt;
        next_rdy_n = rdy_n;
        next_result = result;
        fifo_pop = 1'b0;
        unique case (rstate)
            sprs_pkg::SPRS_EMPTY:
            begin
                if (fifo_valid && !busy_s && !busy_d)
                begin
                    fifo_pop = 1'b1;
                    next_result = fifo_data;
                    next_rdy_n = 1'b0; // RL3
                    next_rstate = sprs_pkg::SPRS_VALID;
                end
            end
            sprs_pkg::SPRS_VALID:
            begin
                if (busy_d && !busy_s)
                begin
                    next_rdy_n = 1'b1;
                    next_rstate = sprs_pkg::SPRS_EMPTY;
                end
                else if (fifo_valid && !busy_s)
                begin
                    next_rdy_n = 1'b1; // RL4
                    next_gap_cnt = 8'(RDY_HIGH_CYCLES - 1);
                    next_rstate = sprs_pkg::SPRS_GAP;
                end
            end
            sprs_pkg::SPRS_GAP:
            begin
                if (busy_s)
                begin
                    next_rstate = sprs_pkg::SPRS_EMPTY;
                end
                else if (gap_cnt == '0)
                begin
                    fifo_pop = 1'b1;
                    next_result = fifo_data;
                    next_rdy_n = 1'b0; // RL3 RL4
                    next_rstate = sprs_pkg::SPRS_VALID;
                end
                else
                begin
                    next_gap_cnt = gap_cnt - 1'b1;
                end
            end
            default:
            begin
                next_rdy_n = 1'b1;
                next_rstate = sprs_pkg::SPRS_EMPTY;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstate <= sprs_pkg::SPRS_EMPTY;
            gap_cnt <= '0;
            rdy_n <= 1'b1;
            result <= '0;
            busy_d <= 1'b0;
        end
        else
        begin
            rstate <= next_rstate;
            gap_cnt <= next_gap_cnt;
            rdy_n <= next_rdy_n;
            result <= next_result;
            busy_d <= busy_s;
        end
    end

    // ****************************************************************
    // Clock source select and crystal pin
    // ****************************************************************
    logic [1:0] clksel;
    logic [1:0] next_clksel;
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;
    logic clk_out;
    logic next_clk_out;
    logic ext_d;
    logic next_tick;

    // Mode word is stable in the link once its toggle is seen here
    always_comb
    begin
        next_clksel = clksel;
        if (cfg_tgl_s != cfg_tgl_d)
        begin
            next_clksel = regs[sprs_pkg::REG_MODE[2:0]][sprs_pkg::MODE_CLKSEL_LSB +: 2];
        end
        next_div_cnt = div_cnt + 1'b1;
        next_clk_out = clk_out;
        if (div_cnt == 8'(sprs_pkg::CLKOUT_HALF - 1))
        begin
            next_div_cnt = '0;
            next_clk_out = !clk_out;
        end
        if (clksel == sprs_pkg::CLKSEL_EXT_IN)
        begin
            next_tick = ext_clk_s && !ext_d;
        end
        else
        begin
            next_tick = (div_cnt == '0) && !clk_out;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clksel <= sprs_pkg::CLKSEL_INT;
            cfg_tgl_d <= 1'b0;
            div_cnt <= '0;
            clk_out <= 1'b0;
            ext_d <= 1'b0;
            mod_clk_tick <= 1'b0;
        end
        else
        begin
            clksel <= next_clksel; // RL12
            cfg_tgl_d <= cfg_tgl_s;
            div_cnt <= next_div_cnt;
            clk_out <= next_clk_out;
            ext_d <= ext_clk_s;
            mod_clk_tick <= next_tick;
        end
    end

    assign clock_source_select = clksel;
    assign crystal2_clock_pin_oe = (clksel == sprs_pkg::CLKSEL_INT_OUT); // RL12
    assign crystal2_clock_pin_out = clk_out;
    assign xtal_osc_en = (clksel == sprs_pkg::CLKSEL_XTAL); // RL12
endmodule : sprs_port

// ### sim/sprs_host.sv
// Host model: serial master whose clock idles high and stops between frames
`timescale 1ns/100ps
module sprs_host (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic so_pin
);
    // ****************************************************************
    // Frame driver
    // ****************************************************************
    // Set by the bench to keep select low across frames, as a 3-wire host does
    logic three_wire = 1'b0;

    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // Half period of 80 ns gives the 160 ns link clock
    task automatic frame(input logic [31:0] tx, output logic [23:0] rx);
        int i;
        rx = 24'h0;
        cs_n = 1'b0;
        #80;
        for (i = 31; i >= 0; i--)
        begin
            sclk = 1'b0;
            din = tx[i];
            #80;
            sclk = 1'b1;
            if (i < 24)
                rx = {rx[22:0], so_pin};
            #80;
        end
        // Released line must not keep showing the last bit
        din = ~din;
        #80;
        cs_n = !three_wire;
        #160;
    endtask : frame
endmodule : sprs_host

// ### sim/sprs_port_sva.sv
// Concurrent checks on the serial port pins
`timescale 1ns/100ps
module sprs_port_sva #(
    parameter int FIFO_DEPTH = 8,
    parameter int RDY_HIGH_CYCLES = sprs_pkg::RDY_HIGH_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic conv_valid,
    input wire logic conv_ready,
    input wire logic crystal2_clock_pin_out,
    input wire logic crystal2_clock_pin_oe,
    input wire logic xtal_osc_en,
    input wire logic [1:0] clock_source_select,
    input wire logic mod_clk_tick
);
    // ****************************************************************
    // Link quiet detector and high-time counter
    // ****************************************************************
    logic [2:0] sclk_q;
    logic [2:0] next_sclk_q;
    logic [3:0] quiet;
    logic [3:0] next_quiet;
    logic [3:0] hi_cnt;
    logic [3:0] next_hi_cnt;
    wire idle = (quiet == 4'hf);

    // Ready checks only hold once the link has been still for a while
    always_comb
    begin
        next_sclk_q = {sclk_q[1:0], sclk};
        next_quiet = (sclk_q[2] != sclk_q[1]) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
        next_hi_cnt = dout ? hi_cnt + 4'h1 : 4'h0;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q <= 3'h7;
            quiet <= 4'h0;
            hi_cnt <= 4'h0;
        end
        else
        begin
            sclk_q <= next_sclk_q;
            quiet <= next_quiet;
            hi_cnt <= next_hi_cnt;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence rdy_gap_s;
        ##[1:8] (!dout && hi_cnt == RDY_HIGH_CYCLES);
    endsequence

    sequence clk_out_s;
        crystal2_clock_pin_out ##1 !crystal2_clock_pin_out [*2] ##1 crystal2_clock_pin_out;
    endsequence

    cs_float_a: assert property (cs_n |-> !dout_oe)
        else $error("output pin driven while deselected");
    cs_drive_a: assert property (!cs_n |-> dout_oe)
        else $error("output pin floating while selected");
    pin_drive_a: assert property (
        crystal2_clock_pin_oe == (clock_source_select == sprs_pkg::CLKSEL_INT_OUT))
        else $error("clock pin drive does not follow select");
    osc_en_a: assert property (
        xtal_osc_en == (clock_source_select == sprs_pkg::CLKSEL_XTAL))
        else $error("oscillator enable does not follow select");
    clk_out_a: assert property (
        clock_source_select == sprs_pkg::CLKSEL_INT_OUT && $rose(crystal2_clock_pin_out)
        |=> clk_out_s)
        else $error("clock out is not a divide by four");
    tick_one_a: assert property (mod_clk_tick |=> !mod_clk_tick)
        else $error("clock tick longer than one cycle");
    rdy_gap_a: assert property (idle && $rose(dout) |-> rdy_gap_s)
        else $error("ready gap of wrong length");
    rdy_low_a: assert property (idle && dout && conv_valid && conv_ready |-> ##[1:8] !dout)
        else $error("ready flag did not fall for new result");
endmodule : sprs_port_sva

bind sprs_port sprs_port_sva #(
    .FIFO_DEPTH(FIFO_DEPTH),
    .RDY_HIGH_CYCLES(RDY_HIGH_CYCLES)
) u_sva (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .dout(dout),
    .dout_oe(dout_oe),
    .conv_valid(conv_valid),
    .conv_ready(conv_ready),
    .crystal2_clock_pin_out(crystal2_clock_pin_out),
    .crystal2_clock_pin_oe(crystal2_clock_pin_oe),
    .xtal_osc_en(xtal_osc_en),
    .clock_source_select(clock_source_select),
    .mod_clk_tick(mod_clk_tick)
);

// ### sim/tb.sv
// Self-checking bench for the serial port and ready logic
`timescale 1ns/100ps
module tb;
    // ****************************************************************
    // Clock, design and host
    // ****************************************************************
    logic clk_sys = 1'b0;
    logic rst_n;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic dout_oe;
    logic conv_valid;
    logic conv_ready;
    logic [23:0] conv_data;
    logic c2_in;
    logic c2_out;
    logic c2_oe;
    logic osc_en;
    logic [1:0] clk_sel;
    logic tick;
    logic [23:0] rx;
    int fails;
    int samples_checked;
    int ticks;
    wire so_pin = dout_oe ? dout : 1'bz;

    always #12.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
        if (tick === 1'b1)
            ticks <= ticks + 1;

    sprs_port #(.FIFO_DEPTH(8), .RDY_HIGH_CYCLES(4)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe), .conv_valid(conv_valid), .conv_ready(conv_ready),
        .conv_data(conv_data), .crystal2_clock_pin_in(c2_in), .crystal2_clock_pin_out(c2_out),
        .crystal2_clock_pin_oe(c2_oe), .xtal_osc_en(osc_en), .clock_source_select(clk_sel),
        .mod_clk_tick(tick));

    sprs_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .so_pin(so_pin));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task end_sim;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // Bounded wait for the ready flag level
    task wait_pin(input logic v);
        int k;
        k = 0;
        while (dout !== v && k < 400)
        begin
            @(posedge clk_sys);
            k++;
        end
        check({23'h0, dout}, {23'h0, v});
        if (dout !== v)
            end_sim;
    endtask : wait_pin

    task push(input logic [23:0] w);
        int k;
        k = 0;
        repeat (20) @(posedge clk_sys);
        conv_valid <= 1'b1;
        conv_data <= w;
        @(posedge clk_sys);
        while (conv_ready !== 1'b1 && k < 400)
        begin
            @(posedge clk_sys);
            k++;
        end
        conv_valid <= 1'b0;
        check({23'h0, conv_ready}, 24'h1);
        if (conv_ready !== 1'b1)
            end_sim;
    endtask : push

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_result;
        check({23'h0, so_pin}, {23'h0, 1'bz});
        push(24'h3c5a96);
        wait_pin(1'b0);
        host.frame({8'h44, 24'h0}, rx);
        check(rx, 24'h3c5a96);
        wait_pin(1'b1);
    endtask : t_result

    // First frames hold select low throughout; framing is by bit count alone
    task t_regs;
        host.three_wire = 1'b1;
        host.frame({8'h02, 24'ha51e7c}, rx);
        check({23'h0, so_pin}, 24'h1);
        host.frame({8'h00, 24'hffffff}, rx);
        host.three_wire = 1'b0;
        host.frame({8'h42, 24'h0}, rx);
        check(rx, 24'ha51e7c);
        host.frame({8'h40, 24'h0}, rx);
        check(rx, 24'h000080);
    endtask : t_regs

    task t_gap;
        push(24'h111111);
        wait_pin(1'b0);
        push(24'h222222);
        wait_pin(1'b1);
        wait_pin(1'b0);
        host.frame({8'h44, 24'h0}, rx);
        check(rx, 24'h222222);
    endtask : t_gap

    // Updates stall during a result read, so the buffer fills up
    task t_fill;
        int n;
        n = 0;
        fork
            host.frame({8'h44, 24'h0}, rx);
            begin
                repeat (80) @(posedge clk_sys);
                conv_valid <= 1'b1;
                conv_data <= 24'h100000;
                repeat (20)
                begin
                    @(posedge clk_sys);
                    if (conv_ready === 1'b1)
                    begin
                        n++;
                        conv_data <= 24'h100000 + n[23:0];
                    end
                end
                conv_valid <= 1'b0;
            end
        join
        check(rx, 24'h222222);
        check(n[23:0], 24'h8);
        repeat (120) @(posedge clk_sys);
        check({23'h0, conv_ready}, 24'h1);
        host.frame({8'h44, 24'h0}, rx);
        check(rx, 24'h100007);
    endtask : t_fill

    task t_clk;
        int i;
        logic [1:0] s;
        for (i = 0; i < 4; i++)
        begin
            s = i[1:0];
            host.frame({8'h01, 20'h0, s, 2'h0}, rx);
            repeat (8) @(posedge clk_sys);
            check({22'h0, clk_sel}, {22'h0, s});
            check({23'h0, c2_oe}, {23'h0, s == 2'h1});
            check({23'h0, osc_en}, {23'h0, s == 2'h3});
            if (s == 2'h2)
            begin
                ticks = 0;
                repeat (3)
                begin
                    c2_in <= 1'b1;
                    repeat (6) @(posedge clk_sys);
                    c2_in <= 1'b0;
                    repeat (6) @(posedge clk_sys);
                end
                check(ticks[23:0], 24'h3);
            end
        end
    endtask : t_clk

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        rst_n = 1'b0;
        conv_valid = 1'b0;
        conv_data = 24'h0;
        c2_in = 1'b0;
        fails = 0;
        samples_checked = 0;
        ticks = 0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_result;
        t_regs;
        t_gap;
        t_fill;
        t_clk;
        end_sim;
    end

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        fails++;
        end_sim;
    end
endmodule : tb
